// File: logic/data_transfer_execution.sv
/*
  Data-transfer execution unit of a small 8-bit core, with its own data
  memory, IO register file and program memory, all reached over APB.
  Assumes one clock, mclk, and an APB master that holds each request.
*/
`timescale 1ns/10ps
// How it works
// - Immediate move loads work register, flags kept.
// - Memory store writes work register, flags kept.
// - Memory load copies byte, updates zero only.
// - IO load copies register, updates zero only.
// - IO store writes work register, flags kept.
// - Negating store writes negated value, flags kept.
// - Negating load negates byte, zero from result.
// - High table read: pointer word, bits 15..8.
// - Low table read: pointer word, bits 7..0.
// - Zero flag is one exactly for zero result.
module data_transfer_execution #(
  parameter int dmem_bytes = 64,
  parameter int io_regs = 16,
  parameter int pmem_words = 256
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import xfer_pkg::*;

  localparam int daw = $clog2(dmem_bytes);
  localparam int iaw = $clog2(io_regs);
  localparam int paw = $clog2(pmem_words);

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [7:0] dmem [dmem_bytes];
  logic [7:0] io_file [io_regs];
  logic [15:0] pmem [pmem_words];
  exec_state_e state;
  logic [3:0] op;
  logic [7:0] arg;
  logic [15:0] pointer;
  logic [7:0] work_register;
  logic zero_flag;
  logic carry_flag;
  logic half_carry_flag;
  logic signed_range_flag;
  logic bad_op;
  logic [3:0] cyc;
  logic [3:0] last_cycles;
  logic ready_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic access;
  logic wr;
  logic in_cmd;
  logic in_work;
  logic in_flag;
  logic in_stat;
  logic in_dmem;
  logic in_io;
  logic in_pmem;
  logic mapped;
  logic [daw-1:0] d_idx;
  logic [iaw-1:0] i_idx;
  logic [paw-1:0] p_idx;
  logic [11:0] d_rel;
  logic [11:0] i_rel;
  logic [11:0] p_rel;

  assign access = psel & penable;
  assign wr = access & pwrite & ready_q;
  assign in_cmd = paddr == cmd_off;
  assign in_work = paddr == work_off;
  assign in_flag = paddr == flag_off;
  assign in_stat = paddr == stat_off;
  assign d_rel = paddr - dmem_base;
  assign i_rel = paddr - io_base;
  assign p_rel = paddr - pmem_base;
  assign in_dmem = paddr >= dmem_base && {20'h00000, d_rel} < 32'(dmem_bytes * 4) && paddr[1:0] == 2'h0;
  assign in_io = paddr >= io_base && {20'h00000, i_rel} < 32'(io_regs * 4) && paddr[1:0] == 2'h0;
  assign in_pmem = paddr >= pmem_base && {20'h00000, p_rel} < 32'(pmem_words * 4) && paddr[1:0] == 2'h0;
  assign mapped = in_cmd | in_work | in_flag | in_stat | in_dmem | in_io | in_pmem;
  assign d_idx = d_rel[daw+1:2];
  assign i_idx = i_rel[iaw+1:2];
  assign p_idx = p_rel[paw+1:2];

  // The answer waits one cycle so read data is sampled only while the unit is
  // idle; a transfer never sees a half-finished instruction.
  assign pready = ready_q;
  assign pslverr = ready_q & ~mapped;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ready_q <= 1'b0;
    end else if (ready_q) begin
      ready_q <= 1'b0;
    end else if (access && state == st_idle) begin
      ready_q <= 1'b1;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (in_work) begin
      rd_mux = {24'h000000, work_register};
    end else if (in_flag) begin
      rd_mux = {28'h0000000, signed_range_flag, half_carry_flag, carry_flag, zero_flag};
    end else if (in_stat) begin
      rd_mux = {20'h00000, last_cycles, 6'h00, state != st_idle, bad_op};
    end else if (in_dmem) begin
      rd_mux = {24'h000000, dmem[d_idx]};
    end else if (in_io) begin
      rd_mux = {24'h000000, io_file[i_idx]};
    end else if (in_pmem) begin
      rd_mux = {16'h0000, pmem[p_idx]};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (access && !pwrite && !ready_q && state == st_idle) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  logic [7:0] mem_byte;
  logic [7:0] io_byte;
  logic [7:0] ptr_lo;
  logic [7:0] ptr_hi;
  logic [15:0] table_word;
  logic [daw-1:0] arg_next;

  assign mem_byte = dmem[arg[daw-1:0]];
  assign io_byte = io_file[arg[iaw-1:0]];
  assign arg_next = arg[daw-1:0] + 1'b1;
  assign ptr_lo = dmem[arg[daw-1:0]];
  assign ptr_hi = dmem[arg_next];
  assign table_word = pmem[pointer[paw-1:0]];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic is_table;
  logic known_op;
  assign is_table = op == op_tab_hi || op == op_tab_lo;
  assign known_op = op <= op_tab_lo;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= st_idle;
      op <= op_mov_imm;
      arg <= 8'h00;
      pointer <= 16'h0000;
      cyc <= cyc_rst;
      last_cycles <= cyc_rst;
    end else begin
      unique case (state)
        st_idle: begin
          if (wr && in_cmd) begin
            op <= pwdata[op_lsb+3:op_lsb];
            arg <= pwdata[arg_lsb+7:arg_lsb];
            cyc <= single_cycles;
            state <= st_exec;
          end
        end
        st_exec: begin
          if (is_table) begin
            pointer <= {ptr_hi, ptr_lo};
            cyc <= table_cycles;
            state <= st_table;
          end else begin
            last_cycles <= cyc;
            state <= st_idle;
          end
        end
        st_table: begin
          last_cycles <= cyc;
          state <= st_idle;
        end
      endcase
    end
  end

  // Unknown opcodes only raise a sticky error and set the last cycle count; a new error wins
  // over a clear in the same cycle.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bad_op <= 1'b0;
    end else if (state == st_exec && !known_op) begin
      bad_op <= 1'b1;
    end else if (wr && in_stat && pwdata[bad_bit]) begin
      bad_op <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Work register and flags
  // ----------------------------------------------------------------
  logic [7:0] next_work;
  logic work_load;
  logic zero_load;

  always_comb begin
    next_work = work_register;
    work_load = 1'b0;
    zero_load = 1'b0;
    if (state == st_exec) begin
      unique case (op)
        op_mov_imm: begin
          next_work = arg;
          work_load = 1'b1;
        end
        op_ld_mem: begin
          next_work = mem_byte;
          work_load = 1'b1;
          zero_load = 1'b1;
        end
        op_ld_io: begin
          next_work = io_byte;
          work_load = 1'b1;
          zero_load = 1'b1;
        end
        op_nld_mem: begin
          next_work = 8'h00 - mem_byte;
          work_load = 1'b1;
          zero_load = 1'b1;
        end
        default: begin
          work_load = 1'b0;
        end
      endcase
    end else if (state == st_table) begin
      next_work = (op == op_tab_hi) ? table_word[15:8] : table_word[7:0];
      work_load = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      work_register <= work_rst;
    end else if (work_load) begin
      work_register <= next_work;
    end else if (wr && in_work) begin
      work_register <= pwdata[7:0];
    end
  end

  // Carry, half carry and signed range change only by software here.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {signed_range_flag, half_carry_flag, carry_flag, zero_flag} <= flags_rst;
    end else if (zero_load) begin
      zero_flag <= next_work == 8'h00;
    end else if (wr && in_flag) begin
      zero_flag <= pwdata[zero_bit];
      carry_flag <= pwdata[carry_bit];
      half_carry_flag <= pwdata[half_bit];
      signed_range_flag <= pwdata[range_bit];
    end
  end

  // ----------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (state == st_exec && op == op_st_mem) begin
      dmem[arg[daw-1:0]] <= work_register;
    end else if (state == st_exec && op == op_nst_mem) begin
      dmem[arg[daw-1:0]] <= 8'h00 - work_register;
    end else if (wr && in_dmem) begin
      dmem[d_idx] <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (state == st_exec && op == op_st_io) begin
      io_file[arg[iaw-1:0]] <= work_register;
    end else if (wr && in_io) begin
      io_file[i_idx] <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (wr && in_pmem) begin
      pmem[p_idx] <= pwdata[15:0];
    end
  end

endmodule

// File: include/xfer_pkg.sv
/*
  Constants for the data-transfer execution unit: register map, field layout,
  reset values, opcodes and cycle counts.
  Assumes a 32-bit APB slave with 12 address bits decoded.
*/
package xfer_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] cmd_off = 12'h000;
  localparam logic [11:0] work_off = 12'h004;
  localparam logic [11:0] flag_off = 12'h008;
  localparam logic [11:0] stat_off = 12'h00c;
  localparam logic [11:0] dmem_base = 12'h100;
  localparam logic [11:0] io_base = 12'h200;
  localparam logic [11:0] pmem_base = 12'h400;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int op_lsb = 0;
  localparam int arg_lsb = 8;
  localparam int zero_bit = 0;
  localparam int carry_bit = 1;
  localparam int half_bit = 2;
  localparam int range_bit = 3;
  localparam int bad_bit = 0;
  localparam int busy_bit = 1;
  localparam int cyc_lsb = 8;

  // ----------------------------------------------------------------
  // Reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic [7:0] work_rst = 8'h00;
  localparam logic [3:0] flags_rst = 4'h0;
  localparam logic [3:0] cyc_rst = 4'h0;
  localparam logic [3:0] single_cycles = 4'h1;
  localparam logic [3:0] table_cycles = 4'h2;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] op_mov_imm = 4'h0;
  localparam logic [3:0] op_st_mem = 4'h1;
  localparam logic [3:0] op_ld_mem = 4'h2;
  localparam logic [3:0] op_ld_io = 4'h3;
  localparam logic [3:0] op_st_io = 4'h4;
  localparam logic [3:0] op_nst_mem = 4'h5;
  localparam logic [3:0] op_nld_mem = 4'h6;
  localparam logic [3:0] op_tab_hi = 4'h7;
  localparam logic [3:0] op_tab_lo = 4'h8;

  typedef enum logic [1:0] {st_idle, st_exec, st_table} exec_state_e;

endpackage

// File: testbench/xfer_checker_assertions.sv
/*
  Port checker of the transfer unit.
  Assumes its APB ports and one clock.
*/
`timescale 1ns/10ps
module xfer_checker
  import xfer_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence cmd_s;
    pready && pwrite && paddr == cmd_off;
  endsequence
  sequence next_s;
    !psel ##1 (psel && !penable) ##1 (psel && penable);
  endsequence
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  quick_answer_a: assert property (cmd_s ##1 next_s |=> pready) else $error("slow answer");
  answer_bound_a: assert property ((psel && !penable) ##1 penable |-> ##[1:3] pready) else $error("no answer");
  misalign_err_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr) else $error("misaligned");
  hole_err_a: assert property (pready && paddr == 12'h010 |-> pslverr) else $error("hole accepted");
  work_width_a: assert property (pready && !pwrite && paddr == work_off |-> prdata[31:8] == 24'h0)
    else $error("work too wide");
endmodule
bind data_transfer_execution xfer_checker i_xfer_checker (.mclk(mclk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// File: testbench/apb_host.sv
/*
  APB host model that stands before the transfer unit.
  Assumes the unit answers with a one-cycle pready.
*/
`timescale 1ns/10ps
module apb_host (
  // Clock
  input wire logic mclk,
  // APB
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // The request is held until pready is seen high at a rising edge; data is taken there.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// File: testbench/data_transfer_execution_bench.sv
/*
  Self-checking bench of the transfer unit.
  Assumes the APB host model and the port checker.
*/
`timescale 1ns/10ps
module data_transfer_execution_bench;
  import xfer_pkg::*;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int bad_count, samples_checked;
  data_transfer_execution i_data_transfer_execution (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  apb_host i_apb_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_apb_host.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    i_apb_host.xfer(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask
  task op(input logic [3:0] o, input logic [7:0] arg);
    wr(cmd_off, {16'h0, arg, 4'h0, o});
  endtask
  function automatic logic [11:0] dm(input int i);
    return dmem_base + 12'(4 * i);
  endfunction
  task report_and_stop;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    rstn = 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    wr(flag_off, 32'he);
    op(op_mov_imm, 8'hf5);
    rd(work_off, 32'hf5);
    rd(stat_off, 32'h100);
    op(op_nst_mem, 8'd9);
    rd(dm(9), 32'h0b);
    rd(work_off, 32'hf5);
    op(op_st_mem, 8'd10);
    rd(dm(10), 32'hf5);
    op(op_st_io, 8'd3);
    rd(io_base + 12'h00c, 32'hf5);
    rd(flag_off, 32'he);
    $display("stores done");
    wr(dm(11), 32'h0);
    op(op_ld_mem, 8'd11);
    rd(work_off, 32'h0);
    rd(flag_off, 32'hf);
    op(op_ld_mem, 8'd10);
    rd(flag_off, 32'he);
    wr(io_base + 12'h014, 32'h0);
    op(op_ld_io, 8'd5);
    rd(flag_off, 32'hf);
    op(op_nld_mem, 8'd9);
    rd(work_off, 32'hf5);
    rd(flag_off, 32'he);
    op(op_nld_mem, 8'd11);
    rd(work_off, 32'h0);
    rd(flag_off, 32'hf);
    $display("loads done");
    wr(dm(20), 32'h05);
    wr(dm(21), 32'h00);
    wr(pmem_base + 12'h014, 32'h1234);
    op(op_tab_hi, 8'd20);
    rd(work_off, 32'h12);
    rd(stat_off, 32'h200);
    op(op_tab_lo, 8'd20);
    rd(work_off, 32'h34);
    rd(flag_off, 32'hf);
    $display("table reads done");
    rd(12'h010, 32'h0);
    check({31'h0, e}, 32'h1);
    wr(12'h006, 32'hff);
    check({31'h0, e}, 32'h1);
    rd(work_off, 32'h34);
    $display("refusals done");
    op(4'h9, 8'h00);
    rd(stat_off, 32'h101);
    rd(work_off, 32'h34);
    wr(stat_off, 32'h1);
    rd(stat_off, 32'h100);
    $display("bad opcode done");
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(work_off, 32'h0);
    rd(flag_off, 32'h0);
    rd(stat_off, 32'h0);
    $display("reset done");
    report_and_stop;
  end
endmodule
